// *** axis_io_pkg.sv ***
// Package: constants and carriers for the axis I/O setup and status block
package axis_io_pkg;

    // ----------------------------------------
    // Command byte layout
    // ----------------------------------------
    localparam logic [1:0] CMD_OUTPUT_SETTING = 2'h3;
    localparam int CMD_CLASS_HI = 7;
    localparam int CMD_CLASS_LO = 6;
    localparam int SET_POLARITY = 0;
    localparam int SET_PULSE_MASK = 1;
    localparam int SET_SEQ_MASK = 2;
    localparam int SET_RAMP_HOLD = 3;
    localparam int SET_FILTER = 4;
    localparam int SET_MONITOR = 5;
    localparam logic [5:0] SETTING_RESET = 6'h20;

    // ----------------------------------------
    // Primary status positions
    // ----------------------------------------
    localparam int PS_STOP_IRQ = 0;
    localparam int PS_RAMPDOWN_IRQ = 1;
    localparam int PS_START_IRQ = 2;
    localparam int PS_BUSY = 3;
    localparam int PS_REM_ZERO = 4;
    localparam int PS_RAMPDOWN = 5;
    localparam int PS_ACCEL = 6;
    localparam int PS_DECEL = 7;

    // ----------------------------------------
    // Extended status positions
    // ----------------------------------------
    localparam int XS_INPUTS_LO = 0;
    localparam int XS_EXC_ORIGIN = 7;
    localparam int XS_PHASE_LO = 8;
    localparam int XS_MINUS_PULSE = 12;
    localparam int XS_PLUS_PULSE = 13;
    localparam int XS_GENERAL = 14;
    localparam int XS_IRQ = 15;

    // ----------------------------------------
    // Timing: filter accepts pulses longer than this many clocks
    // ----------------------------------------
    localparam int FILTER_CYCLES = 3;
    localparam logic [1:0] FILTER_LIMIT = 2'(FILTER_CYCLES);

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    // Sense inputs, active low at the pins
    typedef struct packed {
        logic plus_slowdown;
        logic minus_slowdown;
        logic ext_start;
        logic halt;
        logic origin;
        logic plus_limit;
        logic minus_limit;
    } sense_t;

    // Decoded output-setting fields
    typedef struct packed {
        logic monitor_mode_sel;
        logic input_filter_en;
        logic ramp_hold;
        logic sequence_mask;
        logic pulse_mask;
        logic pulse_polarity_sel;
    } setting_t;

    // Motion state from the ramp generator
    typedef struct packed {
        logic decelerating;
        logic accelerating;
        logic busy;
        logic stop_irq;
        logic rampdown_irq;
        logic start_irq;
    } motion_t;

endpackage

// *** axis_io_setup_and_status.sv ***
// Module: output-setting decode, pin conditioning and status words
// Behaviour
// [R1] Command with bits 7,6 set is output setting
// [R2] Bit 0 picks step polarity and direction sense
// [R3] Bit 1 masks steps, freezes sequence, counter runs
// [R4] Bit 2 forces fixed sequence pattern from mask
// [R5] Port mode leaves pins; phase monitor still follows
// [R6] Bit 3 holds ramp speed, clearing releases
// [R7] Bit 4 filters origin, limit and halt inputs, over 3 clocks
// [R8] Bit 5 monitor mode; serial forces it one
// [R9] Host always writes monitor mode one
// [R10] Primary bits 0-2 irq pending, active low
// [R11] Bit 3 busy, bit 4 remaining zero
// [R12] Bit 5 rampdown passed, 6 accel, 7 decel
// [R13] Extended 0-6 mirror sense pins, low reads one
// [R14] Extended 7 excitation origin position
// [R15] Extended 8-14 phase, pulse, general levels
// [R16] Extended 15 axis interrupt active
`timescale 1ns/10ps
`default_nettype none

module axis_io_setup_and_status
    import axis_io_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Command write from host interface
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_data,
    input wire logic i_serial_if,
    // Environment settings
    input wire logic [3:0] i_mask_value_sel,
    input wire logic i_port_mode_sel,
    input wire logic [3:0] i_port_pin_out,
    // Sense pins, raw and active low
    input wire sense_t i_sense_n,
    // Core motion signals
    input wire motion_t i_motion,
    input wire logic [23:0] i_remaining_pulses,
    input wire logic [23:0] i_rampdown_point,
    input wire logic i_step_req,
    input wire logic i_dir_minus,
    input wire logic [3:0] i_seq_phase,
    input wire logic i_seq_origin,
    input wire logic i_general_out,
    // Settings seen by the core
    output logic o_ramp_hold,
    output logic o_seq_advance,
    output logic o_count_step,
    output sense_t o_sense_n,
    output logic o_monitor_mode_sel,
    output logic [7:0] o_setting_byte,
    // Pins
    output logic o_step_out,
    output logic o_direction_pulse_out,
    output logic [3:0] o_phase_out,
    // Status words
    output logic [7:0] o_primary_status,
    output logic [15:0] o_extended_status
);

    // ----------------------------------------
    // Output-setting register
    // ----------------------------------------
    setting_t set_q;
    logic is_setting;

    assign is_setting = i_cmd_wr &&
        (i_cmd_data[CMD_CLASS_HI:CMD_CLASS_LO] == CMD_OUTPUT_SETTING); // [R1]

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            set_q <= setting_t'(SETTING_RESET);
        end
        else if (is_setting)
        begin
            set_q <= setting_t'(i_cmd_data[5:0]); // [R1]
            // Serial host cannot clear extended monitor; host should
            // always write one anyway
            if (i_serial_if)
            begin
                set_q.monitor_mode_sel <= 1'b1; // [R8] [R9]
            end
        end
        else if (i_serial_if)
        begin
            set_q.monitor_mode_sel <= 1'b1; // [R8]
        end
    end

    assign o_monitor_mode_sel = set_q.monitor_mode_sel; // [R8]
    assign o_setting_byte = {CMD_OUTPUT_SETTING, 6'(set_q)};
    assign o_ramp_hold = set_q.ramp_hold; // [R6]

    // ----------------------------------------
    // Sense input synchronisers and filters
    // ----------------------------------------
    sense_t sync1_q;
    sense_t sync2_q;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
        end
        else
        begin
            sync1_q <= i_sense_n;
            sync2_q <= sync1_q;
        end
    end

    // Each input gets a small run counter; a level only passes after it
    // has held longer than the limit, trading latency for noise immunity
    sense_t filt_q;
    logic [1:0] run_q [7];

    genvar g;
    generate
        for (g = 0; g < 7; g++)
        begin : g_filt
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    run_q[g] <= 2'h0;
                    filt_q[g] <= 1'b1;
                end
                else if (sync2_q[g] == filt_q[g])
                begin
                    run_q[g] <= 2'h0;
                end
                else if (run_q[g] == FILTER_LIMIT)
                begin
                    filt_q[g] <= sync2_q[g]; // [R7]
                    run_q[g] <= 2'h0;
                end
                else
                begin
                    run_q[g] <= run_q[g] + 2'h1;
                end
            end
        end
    endgenerate

    // Only origin, limits and halt are filtered
    sense_t use_filt;
    sense_t sense_n;

    always_comb
    begin
        use_filt = '0;
        use_filt.origin = set_q.input_filter_en; // [R7]
        use_filt.plus_limit = set_q.input_filter_en; // [R7]
        use_filt.minus_limit = set_q.input_filter_en; // [R7]
        use_filt.halt = set_q.input_filter_en; // [R7]
        sense_n = (use_filt & filt_q) | (~use_filt & sync2_q);
    end

    assign o_sense_n = sense_n;

    // ----------------------------------------
    // Step, direction and sequence outputs
    // ----------------------------------------
    logic step_q;
    logic dir_q;
    logic [3:0] phase_q;
    logic [3:0] seq_pat;

    // Counter keeps running even when the pins are masked
    assign o_count_step = i_step_req; // [R3]
    assign o_seq_advance = i_step_req && !set_q.pulse_mask; // [R3]
    assign seq_pat = set_q.sequence_mask ? i_mask_value_sel
                                         : i_seq_phase; // [R4] [R5]

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            step_q <= 1'b1;
            dir_q <= 1'b1;
        end
        else
        begin
            step_q <= (i_step_req && !set_q.pulse_mask)
                      ^ ~set_q.pulse_polarity_sel; // [R2] [R3]
            dir_q <= i_dir_minus ^ ~set_q.pulse_polarity_sel; // [R2]
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase_q <= 4'h0;
        end
        else
        begin
            phase_q <= i_port_mode_sel ? i_port_pin_out : seq_pat; // [R4] [R5]
        end
    end

    assign o_step_out = step_q;
    assign o_direction_pulse_out = dir_q;
    assign o_phase_out = phase_q;

    // ----------------------------------------
    // Status words
    // ----------------------------------------
    logic [7:0] prim_d;
    logic [15:0] ext_d;
    logic [7:0] prim_q;
    logic [15:0] ext_q;

    always_comb
    begin
        prim_d = 8'h00;
        prim_d[PS_STOP_IRQ] = ~i_motion.stop_irq; // [R10]
        prim_d[PS_RAMPDOWN_IRQ] = ~i_motion.rampdown_irq; // [R10]
        prim_d[PS_START_IRQ] = ~i_motion.start_irq; // [R10]
        prim_d[PS_BUSY] = i_motion.busy; // [R11]
        prim_d[PS_REM_ZERO] = (i_remaining_pulses == 24'h000000); // [R11]
        prim_d[PS_RAMPDOWN] = (i_remaining_pulses <= i_rampdown_point); // [R12]
        prim_d[PS_ACCEL] = i_motion.accelerating; // [R12]
        prim_d[PS_DECEL] = i_motion.decelerating; // [R12]
    end

    always_comb
    begin
        ext_d = 16'h0000;
        ext_d[XS_INPUTS_LO +: 7] = ~7'(sense_n); // [R13]
        ext_d[XS_EXC_ORIGIN] = i_seq_origin; // [R14]
        // Monitor follows the sequence even when pins are ports
        ext_d[XS_PHASE_LO +: 4] = seq_pat; // [R5] [R15]
        ext_d[XS_MINUS_PULSE] = dir_q; // [R15]
        ext_d[XS_PLUS_PULSE] = step_q; // [R15]
        ext_d[XS_GENERAL] = i_general_out; // [R15]
        ext_d[XS_IRQ] = i_motion.stop_irq | i_motion.rampdown_irq
                        | i_motion.start_irq; // [R16]
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            prim_q <= 8'h07;
            ext_q <= 16'h0000;
        end
        else
        begin
            prim_q <= prim_d;
            ext_q <= ext_d;
        end
    end

    assign o_primary_status = prim_q;
    assign o_extended_status = ext_q;

endmodule

`default_nettype wire

// *** axis_host_model.sv ***
// Partner model: the host side that writes command bytes
`timescale 1ns/10ps
`default_nettype none
module axis_host_model (
    input wire logic i_clk,
    output logic o_cmd_wr,
    output logic [7:0] o_cmd_data
);
    initial
    begin
        o_cmd_wr = 1'b0;
        o_cmd_data = 8'h00;
    end
    // Legacy write keeps bit 5 as given, for refusal checks and the serial-force check
    task automatic send(input logic [7:0] b, input logic legacy);
        @(negedge i_clk);
        o_cmd_wr = 1'b1;
        o_cmd_data = legacy ? b : b | 8'h20;
        @(negedge i_clk);
        o_cmd_wr = 1'b0;
        // Released bus must not look like it still holds the byte
        o_cmd_data = ~o_cmd_data;
    endtask
endmodule
`default_nettype wire

// *** axis_io_assertions.sv ***
// Checker: port assertions for the axis setup and status block
`timescale 1ns/10ps
`default_nettype none
module axis_io_assertions
    import axis_io_pkg::*;
(
    // Inputs
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_data,
    input wire logic i_serial_if,
    input wire logic [3:0] i_mask_value_sel,
    input wire logic i_port_mode_sel,
    input wire logic [3:0] i_port_pin_out,
    input wire sense_t i_sense_n,
    input wire motion_t i_motion,
    input wire logic [23:0] i_remaining_pulses,
    input wire logic [23:0] i_rampdown_point,
    input wire logic i_step_req,
    input wire logic i_dir_minus,
    input wire logic [3:0] i_seq_phase,
    input wire logic i_seq_origin,
    input wire logic i_general_out,
    // Outputs
    input wire logic o_ramp_hold,
    input wire logic o_seq_advance,
    input wire logic o_count_step,
    input wire logic o_monitor_mode_sel,
    input wire logic [7:0] o_setting_byte,
    input wire logic o_step_out,
    input wire logic o_direction_pulse_out,
    input wire logic [3:0] o_phase_out,
    input wire logic [7:0] o_primary_status,
    input wire logic [15:0] o_extended_status
);
    // Edges since reset, so look-back checks skip reset values
    logic [2:0] up_q;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            up_q <= 3'h0;
        end
        else
        begin
            up_q <= up_q + 3'(up_q != 3'h7);
        end
    end
    wire logic calm = up_q != 3'h0 && !i_cmd_wr;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    a_cmd_decode:
    assert property (up_q != 3'h0 && i_cmd_wr && i_cmd_data[7:6] == 2'h3 |=>
        o_setting_byte == {2'h3, $past(i_cmd_data[5] | i_serial_if),
        $past(i_cmd_data[4:0])}) else $error("setting not taken");
    a_pin_levels:
    assert property (calm |=> o_direction_pulse_out == ($past(i_dir_minus)
        ^ !o_setting_byte[0]) && o_step_out == (o_setting_byte[0]
        ~^ ($past(i_step_req) && !o_setting_byte[1]))) else $error("pins");
    a_step_gate:
    assert property (o_count_step == i_step_req && o_seq_advance ==
        (i_step_req && !o_setting_byte[1])) else $error("step gate");
    a_phase_path:
    assert property (calm |=> o_extended_status[11:8] == (o_setting_byte[2] ?
        $past(i_mask_value_sel) : $past(i_seq_phase)) && o_phase_out ==
        ($past(i_port_mode_sel) ? $past(i_port_pin_out) :
        o_extended_status[11:8])) else $error("phase path");
    a_irq_bits:
    assert property (up_q != 3'h0 |-> o_primary_status[2:0] ==
        ~$past({i_motion.start_irq, i_motion.rampdown_irq, i_motion.stop_irq})
        && o_extended_status[15] == $past(|i_motion[2:0])) else $error("irq");
    a_motion_bits:
    assert property (up_q != 3'h0 |-> o_primary_status[7:3] ==
        $past({i_motion.decelerating, i_motion.accelerating,
        i_remaining_pulses <= i_rampdown_point, i_remaining_pulses == 24'h0,
        i_motion.busy})) else $error("motion bits");
    a_sense_mon:
    assert property (up_q > 3'h3 |-> o_extended_status[6:4] ==
        ~$past(i_sense_n[6:4], 3)) else $error("sense monitor");
    a_mode_outs:
    assert property (o_ramp_hold == o_setting_byte[3] &&
        o_monitor_mode_sel == o_setting_byte[5]) else $error("mode outs");
    a_ext_levels:
    assert property (up_q != 3'h0 |-> o_extended_status[14:12] ==
        {$past(i_general_out), $past(o_step_out),
        $past(o_direction_pulse_out)} && o_extended_status[7] ==
        $past(i_seq_origin)) else $error("ext levels");
    c_serial: cover property (i_cmd_wr && i_serial_if);
    c_masked: cover property (i_step_req && o_setting_byte[1]);
    c_port: cover property (i_port_mode_sel && o_setting_byte[2]);
endmodule
bind axis_io_setup_and_status axis_io_assertions axis_io_assertions_inst (.*);
`default_nettype wire

// *** axis_io_setup_and_status_tb_top.sv ***
// Testbench: directed scenarios for the axis setup and status block
`timescale 1ns/10ps
`default_nettype none
module axis_io_setup_and_status_tb_top;
    import axis_io_pkg::*;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_serial_if = 1'b0;
    logic i_port_mode_sel = 1'b0, i_step_req = 1'b0, i_dir_minus = 1'b0;
    logic i_seq_origin = 1'b0, i_general_out = 1'b0, i_cmd_wr;
    logic [3:0] i_mask_value_sel = 4'ha, i_port_pin_out = 4'h3;
    logic [3:0] i_seq_phase = 4'h5, o_phase_out;
    sense_t i_sense_n = 7'h7f, o_sense_n;
    motion_t i_motion = 6'h00;
    logic [23:0] i_remaining_pulses = 24'h0, i_rampdown_point = 24'h0;
    logic [7:0] i_cmd_data, o_setting_byte, o_primary_status;
    logic o_ramp_hold, o_seq_advance, o_count_step, o_monitor_mode_sel;
    logic o_step_out, o_direction_pulse_out;
    logic [15:0] o_extended_status;
    int err_total = 0, checks = 0, ticks = 0;
    axis_io_setup_and_status axis_io_setup_and_status_inst (.*);
    axis_host_model axis_host_model_inst (.i_clk(i_clk), .o_cmd_wr(i_cmd_wr),
        .o_cmd_data(i_cmd_data));
    always #5 i_clk = ~i_clk;
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge i_clk)
    begin
        ticks++;
        if (ticks == 2000)
        begin
            err_total++;
            close_out();
        end
    end
    task automatic t_pulse();
        logic [7:0] s;
        for (int k = 0; k < 4; k++)
        begin
            s = 8'he0 | 8'(k);
            i_dir_minus = k[1];
            axis_host_model_inst.send(s, 1'b0);
            i_step_req = 1'b1;
            #1;
            chk("gate", {!s[1], 1'b1}, {o_seq_advance, o_count_step});
            cyc(1);
            i_step_req = 1'b0;
            chk("step", s[1] ? !s[0] : s[0], o_step_out);
            chk("dir", k[1] ^ !s[0], o_direction_pulse_out);
        end
        $display("Test pulse done");
    endtask
    task automatic t_class();
        axis_host_model_inst.send(8'hc8, 1'b0);
        chk("hold", 2'h3, {o_monitor_mode_sel, o_ramp_hold});
        for (int k = 0; k < 3; k++)
        begin
            axis_host_model_inst.send(8'(k * 64 + 63), 1'b1);
            chk("other", 8'he8, o_setting_byte);
        end
        i_serial_if = 1'b1;
        axis_host_model_inst.send(8'hc0, 1'b1);
        chk("serial", 9'h0e0, {o_ramp_hold, o_setting_byte});
        i_serial_if = 1'b0;
        $display("Test command done");
    endtask
    task automatic t_phase();
        axis_host_model_inst.send(8'he4, 1'b0);
        cyc(1);
        chk("mask", 8'haa, {o_phase_out, o_extended_status[11:8]});
        i_port_mode_sel = 1'b1;
        cyc(2);
        chk("port", 8'h3a, {o_phase_out, o_extended_status[11:8]});
        i_port_mode_sel = 1'b0;
        axis_host_model_inst.send(8'he0, 1'b0);
        cyc(1);
        chk("seq", 8'h55, {o_phase_out, o_extended_status[11:8]});
        $display("Test phase done");
    endtask
    task automatic t_status();
        motion_t m [4] = '{6'h3f, 6'h00, 6'h15, 6'h2a};
        logic [23:0] r [4] = '{24'h0, 24'h5, 24'h4, 24'hffffff};
        logic [23:0] d [4] = '{24'h0, 24'h4, 24'h5, 24'hffffff};
        for (int k = 0; k < 4; k++)
        begin
            i_motion = m[k];
            i_remaining_pulses = r[k];
            i_rampdown_point = d[k];
            i_seq_origin = k[0];
            i_general_out = k[1];
            cyc(2);
            chk("levels", {k[1], 1'b1, 1'b0, k[0]},
                {o_extended_status[14:12], o_extended_status[7]});
            chk("primary", {m[k].decelerating, m[k].accelerating,
                r[k] <= d[k], r[k] == 24'h0, m[k].busy, !m[k].start_irq,
                !m[k].rampdown_irq, !m[k].stop_irq},
                o_primary_status);
            chk("irq", |m[k][2:0], o_extended_status[15]);
        end
        $display("Test status done");
    endtask
    task automatic t_sense();
        for (int k = 0; k < 7; k++)
        begin
            i_sense_n = ~(7'h1 << k);
            cyc(4);
            chk("mirror", 7'h1 << k, o_extended_status[6:0]);
            chk("sense", 7'(~(7'h1 << k)), o_sense_n);
        end
        i_sense_n = 7'h7f;
        axis_host_model_inst.send(8'hf0, 1'b0);
        i_sense_n.halt = 1'b0;
        cyc(3);
        i_sense_n.halt = 1'b1;
        cyc(6);
        chk("short", 1'b0, o_extended_status[3]);
        chk("short_n", 1'b1, o_sense_n.halt);
        i_sense_n.halt = 1'b0;
        cyc(8);
        chk("long", 1'b1, o_extended_status[3]);
        $display("Test filter done");
    endtask
    initial
    begin
        cyc(8);
        i_rstn = 1'b1;
        cyc(1);
        t_pulse();
        t_class();
        t_phase();
        t_status();
        t_sense();
        close_out();
    end
endmodule
`default_nettype wire
